/* rtl/med_pkg.sv */
package med_pkg;
  // ************************************************************
  // register map (byte addresses, one aligned word each)
  // ************************************************************
  localparam logic [4:0] GEN_CTRL_OFS  = 5'h00; // general control
  localparam logic [4:0] GEN_STAT_OFS  = 5'h04; // general status
  localparam logic [4:0] MGMT_CFG_OFS  = 5'h08; // management config
  localparam logic [4:0] MGMT_DATA_OFS = 5'h0C; // management data pin

  // ************************************************************
  // general control fields
  // ************************************************************
  localparam int CTL_CODEC_BIT   = 0; // serial_codec_mode
  localparam int CTL_LOOP_BIT    = 1; // loopback_ctl
  localparam int CTL_VENDOR_BIT  = 2; // vendor transceiver mode
  localparam int CTL_CABLE_BIT   = 3; // cable_type_sel
  localparam int CTL_PORT_LO     = 4; // port_type_sel[0]
  localparam int CTL_PORT_HI     = 5; // port_type_sel[1]
  localparam int CTL_PDN_BIT     = 6; // power_down_ctl
  localparam int CTL_LNKDIS_BIT  = 7; // link_disable_ctl
  localparam logic [7:0] CTL_RESET = 8'h00;

  // ************************************************************
  // general status fields
  // ************************************************************
  localparam int STA_CRS_BIT   = 0;  // live carrier sense
  localparam int STA_COL_BIT   = 1;  // live collision
  localparam int STA_MDC_BIT   = 2;  // management clock level
  localparam int STA_RXDV_BIT  = 10; // gp input, rx data valid pin
  localparam int STA_RXER_BIT  = 11; // gp input, rx error pin
  localparam int STA_RXD3_BIT  = 12; // gp input, rx data line 3
  localparam int STA_RXD1_BIT  = 13; // gp input, rx data line 1
  localparam int STA_RXD2_BIT  = 15; // gp input, rx data line 2

  // ************************************************************
  // management config / data fields
  // ************************************************************
  localparam logic [2:0] CLKSEL_RESET   = 3'h7;  // slowest clock
  localparam logic [9:0] MDC_HALF_BASE  = 10'h004; // half period, sel 0
  localparam int MDD_OUT_BIT = 0; // value driven on data pin
  localparam int MDD_OE_BIT  = 1; // drive enable of data pin
  localparam int MDD_IN_BIT  = 2; // synchronised pin level
  localparam logic [1:0] MDD_RESET = 2'h0;
endpackage : med_pkg

/* rtl/med_sync.sv */
`timescale 1ns/1ps
// two-flop level synchroniser, stage one read only by stage two
module med_sync #(
  parameter int W = 6
) (
  input  wire logic         sys_clk_in,
  input  wire logic         sys_rst_in,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);
  typedef struct packed {
    logic [W-1:0] s1; // metastability catcher
    logic [W-1:0] s2; // safe output
  } med_sync_t;

  med_sync_t st_reg;
  med_sync_t st_next;

  // shift one stage per clock
  always_comb begin
    st_next.s1 = d_in;
    st_next.s2 = st_reg.s1;
  end

  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign q_out = st_reg.s2;
endmodule : med_sync

/* rtl/med_clkdiv.sv */
`timescale 1ns/1ps
// one-cycle tick every half period of the management clock
module med_clkdiv (
  input  wire logic       sys_clk_in,
  input  wire logic       sys_rst_in,
  input  wire logic [2:0] sel_in,
  output logic            tick_out
);
  typedef struct packed {
    logic [9:0] cnt;  // cycles left in this half period
    logic       tick; // registered tick
  } med_div_t;

  med_div_t st_reg;
  med_div_t st_next;
  logic [9:0] half_len; // half period in system cycles

  // half period doubles with each step of the select field
  always_comb begin
    half_len = 10'(MDC_HALF_LEN(sel_in));
    st_next  = st_reg;
    st_next.tick = 1'b0;
    if (st_reg.cnt == 10'h000) begin
      st_next.cnt  = 10'(half_len - 10'h001);
      st_next.tick = 1'b1;
    end else begin
      st_next.cnt = 10'(st_reg.cnt - 10'h001);
    end
  end

  function automatic logic [9:0] MDC_HALF_LEN(input logic [2:0] s);
    MDC_HALF_LEN = 10'(med_pkg::MDC_HALF_BASE << s);
  endfunction : MDC_HALF_LEN

  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign tick_out = st_reg.tick;
endmodule : med_clkdiv

/* rtl/med_mii_if.sv */
`timescale 1ns/1ps
// Function
// - codec mode gp pins from control/status regs
// - mgmt clock pin = loopback xor vendor mode
// - mgmt data pin outputs cable type select
// - tx line 3/2 from port type bits 0/1
// - tx line 1 inverted power-down, open collector
// - tx error pin shows link disable bit
// - codec serial transmit on tx line 0 only
// - codec serial receive on rx line 0 only
// - rx lines 3/2/1 in status 12/15/13
// - rx error bit 11, rx valid bit 10
// - mgmt clock divided by select field
// - mgmt data shared, drive only when released
// - tx nibble driven on phy tx clock
// - tx enable exactly with valid tx data
// - tx error flags error in stream
// - rx nibble sampled on phy rx clock
module med_mii_if (
  input  wire logic        sys_clk_in,
  input  wire logic        sys_rst_in,
  // ahb-lite slave
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic        hready_in,
  output logic      [31:0] hrdata_out,
  output logic             hreadyout_out,
  output logic             hresp_out,
  // mac transmit side
  input  wire logic [3:0]  tx_data_in,
  input  wire logic        tx_valid_in,
  input  wire logic        tx_err_in,
  output logic             tx_take_out,
  // mac receive side
  output logic      [3:0]  rx_data_out,
  output logic             rx_valid_out,
  output logic             rx_err_out,
  output logic             crs_out,
  output logic             col_out,
  // phy pins
  output logic             mdc_out,
  input  wire logic        mdio_in,
  output logic             mdio_out,
  output logic             mdio_oe_out,
  input  wire logic        txclk_in,
  output logic      [3:0]  txd_out,
  output logic             txd1_oe_out,
  output logic             txen_out,
  output logic             txer_out,
  input  wire logic        col_in,
  input  wire logic        crs_in,
  input  wire logic        rxclk_in,
  input  wire logic [3:0]  rxd_in,
  input  wire logic        rxer_in,
  input  wire logic        rxdv_in
);
  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    logic [7:0]  ctrl;     // general control
    logic [2:0]  clk_sel;  // management clock select
    logic [1:0]  mdd;      // software data pin value / enable
    logic        wr_pend;  // write data phase pending
    logic [4:0]  wr_addr;  // address of pending write
    logic [31:0] hrdata;   // read data
    logic        hready;   // reset loads 0, ready from first clock after reset, zero wait
    logic        txclk_q;  // previous tx clock level
    logic        rxclk_q;  // previous rx clock level
    logic [3:0]  txd;
    logic        txd1_oe;
    logic        txen;
    logic        txer;
    logic        tx_take;
    logic        mdc;
    logic        mdio_o;
    logic        mdio_oe;
    logic [3:0]  rxd;
    logic        rx_valid;
    logic        rx_err;
    logic        crs;
    logic        col;
  } med_state_t;

  med_state_t st_reg;
  med_state_t st_next;

  logic       mdc_tick;  // half-period tick of management clock
  logic [5:0] gp_sync;   // {mdio, rxdv, rxer, rxd3..1} synchronised
  logic [31:0] stat_word; // live status word
  logic       codec;     // serial codec mode selected
  logic       tx_fall;   // falling edge of phy tx clock
  logic       rx_rise;   // rising edge of phy rx clock
  logic       addr_ph;   // valid address phase

  // ************************************************************
  // helpers
  // ************************************************************
  med_clkdiv u_div (
    .sys_clk_in (sys_clk_in),
    .sys_rst_in (sys_rst_in),
    .sel_in     (st_reg.clk_sel),
    .tick_out   (mdc_tick)
  );

  // gp inputs cross through two flops before software sees them
  med_sync #(.W(6)) u_sync (
    .sys_clk_in (sys_clk_in),
    .sys_rst_in (sys_rst_in),
    .d_in       ({mdio_in, rxdv_in, rxer_in, rxd_in[3:1]}),
    .q_out      (gp_sync)
  );

  // word index decode, used for both reads and writes
  function automatic logic [4:0] word_addr(input logic [31:0] a);
    word_addr = {a[4:2], 2'h0};
  endfunction : word_addr

  // ************************************************************
  // status word
  // ************************************************************
  always_comb begin
    stat_word = '0;
    stat_word[med_pkg::STA_CRS_BIT]  = st_reg.crs;
    stat_word[med_pkg::STA_COL_BIT]  = st_reg.col;
    stat_word[med_pkg::STA_MDC_BIT]  = st_reg.mdc;
    stat_word[med_pkg::STA_RXD1_BIT] = gp_sync[0];
    stat_word[med_pkg::STA_RXD2_BIT] = gp_sync[1];
    stat_word[med_pkg::STA_RXD3_BIT] = gp_sync[2];
    stat_word[med_pkg::STA_RXER_BIT] = gp_sync[3];
    stat_word[med_pkg::STA_RXDV_BIT] = gp_sync[4];
  end

  assign codec   = st_reg.ctrl[med_pkg::CTL_CODEC_BIT];
  assign tx_fall = st_reg.txclk_q & ~txclk_in;
  assign rx_rise = ~st_reg.rxclk_q & rxclk_in;
  assign addr_ph = hsel_in & hready_in & htrans_in[1];

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    st_next = st_reg;
    st_next.hready  = 1'b1;
    st_next.txclk_q = txclk_in;
    st_next.rxclk_q = rxclk_in;
    st_next.tx_take = 1'b0;
    st_next.rx_valid = 1'b0;

    // bus write lands in its data phase
    if (st_reg.wr_pend) begin
      case (st_reg.wr_addr)
        med_pkg::GEN_CTRL_OFS:  st_next.ctrl    = hwdata_in[7:0];
        med_pkg::MGMT_CFG_OFS:  st_next.clk_sel = hwdata_in[2:0];
        med_pkg::MGMT_DATA_OFS: st_next.mdd     = hwdata_in[1:0];
        default: ; // unmapped or read-only, ignored
      endcase
    end
    st_next.wr_pend = addr_ph & hwrite_in;
    st_next.wr_addr = word_addr(haddr_in);

    // read data prepared in address phase; unmapped reads zero
    if (addr_ph & ~hwrite_in) begin
      case (word_addr(haddr_in))
        med_pkg::GEN_CTRL_OFS:  st_next.hrdata = {24'h000000, st_reg.ctrl};
        med_pkg::GEN_STAT_OFS:  st_next.hrdata = stat_word;
        med_pkg::MGMT_CFG_OFS:  st_next.hrdata = {29'h0, st_reg.clk_sel};
        med_pkg::MGMT_DATA_OFS:
          st_next.hrdata = {29'h0, gp_sync[5], st_reg.mdd};
        default:                st_next.hrdata = 32'h0000_0000;
      endcase
    end

    // carrier and collision are levels kept by the phy
    st_next.crs = crs_in;
    st_next.col = col_in;

    if (codec) begin
      // pins become general-purpose outputs of the control reg
      st_next.mdc = st_reg.ctrl[med_pkg::CTL_LOOP_BIT] ^
                    st_reg.ctrl[med_pkg::CTL_VENDOR_BIT];
      st_next.mdio_o  = st_reg.ctrl[med_pkg::CTL_CABLE_BIT];
      st_next.mdio_oe = 1'b1;
      st_next.txd[3]  = st_reg.ctrl[med_pkg::CTL_PORT_LO];
      st_next.txd[2]  = st_reg.ctrl[med_pkg::CTL_PORT_HI];
      // open collector: only ever pulls the line low
      st_next.txd[1]  = ~st_reg.ctrl[med_pkg::CTL_PDN_BIT];
      st_next.txd1_oe = st_reg.ctrl[med_pkg::CTL_PDN_BIT];
      st_next.txer    = st_reg.ctrl[med_pkg::CTL_LNKDIS_BIT];
      if (tx_fall) begin
        // serial bit on line 0 only
        st_next.txd[0]  = tx_valid_in ? tx_data_in[0] : 1'b0;
        st_next.txen    = tx_valid_in;
        st_next.tx_take = tx_valid_in;
      end
      if (rx_rise) begin
        st_next.rxd      = {3'h0, rxd_in[0]};
        st_next.rx_valid = 1'b1;
        st_next.rx_err   = 1'b0;
      end
    end else begin
      // divided management clock toggles on each half-period tick
      if (mdc_tick) begin
        st_next.mdc = ~st_reg.mdc;
      end
      // software owns the data pin; it must release before phy drives
      st_next.mdio_o  = st_reg.mdd[med_pkg::MDD_OUT_BIT];
      st_next.mdio_oe = st_reg.mdd[med_pkg::MDD_OE_BIT];
      st_next.txd1_oe = 1'b1;
      // change on falling edge so data is settled at phy rising edge
      if (tx_fall) begin
        st_next.txd     = tx_valid_in ? tx_data_in : 4'h0;
        st_next.txen    = tx_valid_in;
        st_next.txer    = tx_valid_in & tx_err_in;
        st_next.tx_take = tx_valid_in;
      end
      if (rx_rise) begin
        st_next.rxd      = rxd_in;
        st_next.rx_valid = rxdv_in;
        st_next.rx_err   = rxdv_in & rxer_in;
      end
    end
  end

  // ************************************************************
  // registers
  // ************************************************************
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      st_reg         <= '0;
      st_reg.ctrl    <= med_pkg::CTL_RESET;
      st_reg.clk_sel <= med_pkg::CLKSEL_RESET;
      st_reg.mdd     <= med_pkg::MDD_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs, all straight from flops except hresp_out, tied low
  assign hrdata_out    = st_reg.hrdata;
  assign hreadyout_out = st_reg.hready;
  assign hresp_out     = 1'b0;
  assign tx_take_out   = st_reg.tx_take;
  assign rx_data_out   = st_reg.rxd;
  assign rx_valid_out  = st_reg.rx_valid;
  assign rx_err_out    = st_reg.rx_err;
  assign crs_out       = st_reg.crs;
  assign col_out       = st_reg.col;
  assign mdc_out       = st_reg.mdc;
  assign mdio_out      = st_reg.mdio_o;
  assign mdio_oe_out   = st_reg.mdio_oe;
  assign txd_out       = st_reg.txd;
  assign txd1_oe_out   = st_reg.txd1_oe;
  assign txen_out      = st_reg.txen;
  assign txer_out      = st_reg.txer;

  // ************************************************************
  // assertions
  // ************************************************************
  property p_mdc_xor;
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    codec |=> mdc_out == $past(st_reg.ctrl[1] ^ st_reg.ctrl[2]);
  endproperty
  a_mdc_xor: assert property (p_mdc_xor)
    else $error("mgmt clock not loopback xor vendor in codec mode");

  property p_mdio_cable;
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    codec |=> mdio_oe_out && (mdio_out == $past(st_reg.ctrl[3]));
  endproperty
  a_mdio_cable: assert property (p_mdio_cable)
    else $error("mgmt data pin not cable select in codec mode");

  property p_port_type;
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    codec |=> txd_out[3:2] == {$past(st_reg.ctrl[4]),
                               $past(st_reg.ctrl[5])};
  endproperty
  a_port_type: assert property (p_port_type)
    else $error("tx lines 3/2 do not follow port type bits");

  property p_pdn_oc;
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    codec ##1 codec |-> (txd1_oe_out == $past(st_reg.ctrl[6])) &&
                        (!txd1_oe_out || !txd_out[1]);
  endproperty
  a_pdn_oc: assert property (p_pdn_oc)
    else $error("tx line 1 open collector wrong");

  property p_lnkdis;
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    codec |=> txer_out == $past(st_reg.ctrl[7]);
  endproperty
  a_lnkdis: assert property (p_lnkdis)
    else $error("tx error pin not link disable in codec mode");

  property p_serial_rx;
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    (codec && rx_rise) |=> rx_valid_out && rx_data_out[3:1] == 3'h0;
  endproperty
  a_serial_rx: assert property (p_serial_rx)
    else $error("serial receive used more than line 0");

  property p_gp_rxd3;
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    rxd_in[3] [*3] |-> stat_word[12];
  endproperty
  a_gp_rxd3: assert property (p_gp_rxd3)
    else $error("status bit 12 does not follow rx line 3");

  property p_gp_rxdv;
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    !rxdv_in ##1 rxdv_in |=> !stat_word[10] ##1 stat_word[10];
  endproperty
  a_gp_rxdv: assert property (p_gp_rxdv)
    else $error("rx valid status not two flops behind pin");

  property p_txen_valid;
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    (!codec && tx_fall) |=> txen_out == $past(tx_valid_in) &&
                            (txen_out || txd_out == 4'h0);
  endproperty
  a_txen_valid: assert property (p_txen_valid)
    else $error("tx enable not aligned with tx data");

  property p_mdc_tick;
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    (!codec && $past(!codec) && $changed(mdc_out)) |-> $past(mdc_tick);
  endproperty
  a_mdc_tick: assert property (p_mdc_tick)
    else $error("mgmt clock toggled without divider tick");
endmodule : med_mii_if

/* tb/med_phy_model.sv */
`timescale 1ns/1ps
// ****************************************
// phy partner: clocks, receive beats, levels
// ****************************************
module med_phy_model (
  input  wire logic       mdio_oe_in,  // device drives mdio
  input  wire logic [3:0] txd_in,      // device tx nibble
  input  wire logic       txen_in,     // device tx enable
  input  wire logic       txer_in,     // device tx error
  output logic            txclk_out,   // phy tx clock
  output logic            rxclk_out,   // phy rx clock
  output logic      [3:0] rxd_out,     // rx nibble
  output logic            rxdv_out,    // rx data valid
  output logic            rxer_out,    // rx error
  output logic            col_out,     // collision
  output logic            crs_out,     // carrier sense
  output logic            mdio_oe_out, // phy drives mdio
  output logic            mdio_out     // phy mdio value
);
  localparam int HALF = 20; // 25 MHz clocks, half period in ns
  logic [5:0] tx_q[$];      // captured {txer, txen, txd}

  // clocks stand still outside frames
  initial begin
    txclk_out = 1'b0;
    rxclk_out = 1'b0;
    rxd_out = 4'h0;
    rxdv_out = 1'b0;
    rxer_out = 1'b0;
    col_out = 1'b0;
    crs_out = 1'b0;
    mdio_oe_out = 1'b0;
    mdio_out = 1'b0;
  end

  // n tx clock periods; device nibble taken at each rising edge
  task automatic tx_clocks(input int n);
    #1;
    repeat (n) begin
      txclk_out = 1'b1;
      tx_q.push_back({txer_in, txen_in, txd_in});
      #HALF txclk_out = 1'b0;
      #HALF;
    end
  endtask : tx_clocks

  // one receive beat, set up half a period before the rise
  task automatic send_rx(input logic [3:0] d, input logic dv, er);
    #1;
    rxd_out = d;
    rxdv_out = dv;
    rxer_out = er;
    #HALF rxclk_out = 1'b1;
    #HALF rxclk_out = 1'b0;
    rxd_out = ~d;     // hold time over: no stale value left
    rxdv_out = 1'b0;
    rxer_out = 1'b0;
  endtask : send_rx

  // static levels on lines read as gp inputs
  task automatic set_gp(input logic [3:0] d, input logic dv, er);
    #1;
    rxd_out = d;
    rxdv_out = dv;
    rxer_out = er;
  endtask : set_gp

  // medium state
  task automatic set_line(input logic col, crs);
    #1;
    col_out = col;
    crs_out = crs;
  endtask : set_line

  // drive mdio only once the device has let go
  task automatic drive_mdio(input logic v);
    #1;
    while (mdio_oe_in) #HALF;
    mdio_oe_out = 1'b1;
    mdio_out = v;
  endtask : drive_mdio

  task automatic release_mdio;
    #1;
    mdio_oe_out = 1'b0;
  endtask : release_mdio
endmodule : med_phy_model

/* tb/med_mii_if_tb.sv */
`timescale 1ns/1ps
// ****************************************
// bench for the mii / serial codec pins
// ****************************************
module med_mii_if_tb;
  localparam logic [31:0] CTRL = 32'(med_pkg::GEN_CTRL_OFS);
  localparam logic [31:0] STA = 32'(med_pkg::GEN_STAT_OFS);
  localparam logic [31:0] CFG = 32'(med_pkg::MGMT_CFG_OFS);
  localparam logic [31:0] MDD = 32'(med_pkg::MGMT_DATA_OFS);
  // short aliases of field positions, keeps checks on one line
  localparam int LB = med_pkg::CTL_LOOP_BIT, VB = med_pkg::CTL_VENDOR_BIT,
    CB = med_pkg::CTL_CABLE_BIT, P0 = med_pkg::CTL_PORT_LO,
    P1 = med_pkg::CTL_PORT_HI, PD = med_pkg::CTL_PDN_BIT,
    LD = med_pkg::CTL_LNKDIS_BIT, S3 = med_pkg::STA_RXD3_BIT,
    S2 = med_pkg::STA_RXD2_BIT, S1 = med_pkg::STA_RXD1_BIT,
    SE = med_pkg::STA_RXER_BIT, SV = med_pkg::STA_RXDV_BIT;
  logic        sys_clk, sys_rst, hsel, hwrite, hready, hresp; // bus
  logic [1:0]  htrans;                     // transfer kind
  logic [2:0]  hsize;                      // transfer size
  logic [31:0] haddr, hwdata, hrdata, v;   // bus words, read value
  logic [3:0]  tx_data, rx_data, txd, rxd; // nibbles
  logic        tx_valid, tx_err, tx_take, rx_valid, rx_err;
  logic        crs_mac, col_mac, mdc, mdio_o, mdio_oe, mdio_line;
  logic        txclk, txd1_oe, txen, txer, col, crs, rxclk;
  logic        rxer, rxdv, phy_md_oe, phy_md;
  logic [7:0]  c, ctl[4];                  // control patterns
  logic [5:0]  gpt[2];                     // {rxd, dv, er} levels
  logic [4:0]  rx_q[$];                    // delivered {err, nibble}
  int          errors, comparisons, cycles, n;

  // pull-up holds mdio high when nobody drives it
  assign mdio_line = mdio_oe ? mdio_o : (phy_md_oe ? phy_md : 1'b1);

  med_mii_if med_mii_if_inst (
    .sys_clk_in(sys_clk), .sys_rst_in(sys_rst), .hsel_in(hsel),
    .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
    .hsize_in(hsize), .hwdata_in(hwdata), .hready_in(hready),
    .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
    .tx_data_in(tx_data), .tx_valid_in(tx_valid), .tx_err_in(tx_err),
    .tx_take_out(tx_take), .rx_data_out(rx_data),
    .rx_valid_out(rx_valid), .rx_err_out(rx_err), .crs_out(crs_mac),
    .col_out(col_mac), .mdc_out(mdc), .mdio_in(mdio_line),
    .mdio_out(mdio_o), .mdio_oe_out(mdio_oe), .txclk_in(txclk),
    .txd_out(txd), .txd1_oe_out(txd1_oe), .txen_out(txen),
    .txer_out(txer), .col_in(col), .crs_in(crs), .rxclk_in(rxclk),
    .rxd_in(rxd), .rxer_in(rxer), .rxdv_in(rxdv));

  med_phy_model med_phy_model_inst (
    .mdio_oe_in(mdio_oe), .txd_in(txd), .txen_in(txen),
    .txer_in(txer), .txclk_out(txclk), .rxclk_out(rxclk),
    .rxd_out(rxd), .rxdv_out(rxdv), .rxer_out(rxer), .col_out(col),
    .crs_out(crs), .mdio_oe_out(phy_md_oe), .mdio_out(phy_md));

  // 250 MHz system clock
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  // hang guard: whole run needs under a thousand cycles
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      wrap_up();
    end
  end

  // collect every beat the device hands to the mac
  always @(posedge sys_clk) begin
    if (rx_valid === 1'b1) begin
      rx_q.push_back({rx_err, rx_data});
    end
  end

  task automatic check(input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wrap_up;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : wrap_up

  // single word transfer; both phases wait for hready
  task automatic xfer(input logic [31:0] a, d, input logic w,
                      output logic [31:0] r);
    @(posedge sys_clk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge sys_clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge sys_clk); while (hready !== 1'b1);
    r = hrdata;
  endtask : xfer

  task automatic wr(input logic [31:0] a, d);
    logic [31:0] r;
    xfer(a, d, 1'b1, r);
  endtask : wr

  task automatic rd(input logic [31:0] a, output logic [31:0] r);
    xfer(a, 32'h0, 1'b0, r);
  endtask : rd

  // cycles until the management clock level changes
  task automatic wait_mdc(output int k);
    logic m;
    m = mdc;
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (mdc === m && k < 2000);
  endtask : wait_mdc

  // offer one nibble and hold it until the device takes it
  task automatic send_tx(input logic [3:0] d, input logic e);
    int k;
    @(posedge sys_clk);
    tx_data <= d;
    tx_valid <= 1'b1;
    tx_err <= e;
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (tx_take !== 1'b1 && k < 100);
    tx_valid <= 1'b0;
    tx_err <= 1'b0;
  endtask : send_tx

  // two back-to-back nibbles over four phy clock periods
  task automatic tx_run(input logic [3:0] d0, d1, input logic e0, e1);
    med_phy_model_inst.tx_q.delete();
    fork
      med_phy_model_inst.tx_clocks(4);
    join_none
    send_tx(d0, e0);
    send_tx(d1, e1);
    wait fork;
  endtask : tx_run

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    sys_rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    tx_data = 4'h0;
    tx_valid = 1'b0;
    tx_err = 1'b0;
    ctl = '{8'h01, 8'h5B, 8'hA7, 8'hFD};
    gpt = '{6'b1010_0_1, 6'b0100_1_0};
    repeat (5) @(posedge sys_clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    // reset values, unmapped word reads zero and ignores writes
    rd(CTRL, v);
    check(v, 32'h0);
    check(32'(hresp), 32'h0);
    rd(CFG, v);
    check(v, 32'(med_pkg::CLKSEL_RESET));
    wr(32'h0000_0010, 32'hFFFF_FFFF);
    rd(32'h0000_0010, v);
    check(v, 32'h0);
    // management clock half period for select values 0 and 1
    for (int s = 0; s < 2; s++) begin
      wr(CFG, 32'(s));
      wait_mdc(n);
      wait_mdc(n);
      wait_mdc(n);
      check(32'(n), 32'(med_pkg::MDC_HALF_BASE) << s);
    end
    // shared data line: device drives, releases, phy drives
    wr(MDD, 32'h2);
    repeat (2) @(posedge sys_clk);
    check(32'(mdio_line), 32'h0);
    wr(MDD, 32'h0);
    repeat (2) @(posedge sys_clk);
    check(32'(mdio_line), 32'h1);
    rd(MDD, v);
    check(v, 32'h4);
    med_phy_model_inst.drive_mdio(1'b0);
    repeat (4) @(posedge sys_clk);
    rd(MDD, v);
    check(v, 32'h0);
    med_phy_model_inst.release_mdio();
    // collision and carrier seen live
    for (int i = 1; i < 3; i++) begin
      med_phy_model_inst.set_line(i[1], i[0]);
      repeat (4) @(posedge sys_clk);
      rd(STA, v);
      check({v[med_pkg::STA_COL_BIT], v[med_pkg::STA_CRS_BIT]}, 32'(i));
      check({col_mac, crs_mac}, 32'(i));
    end
    // mii transmit: idle, two nibbles, error on the second, idle
    tx_run(4'hA, 4'h5, 1'b0, 1'b1);
    check(med_phy_model_inst.tx_q[0], 6'h00);
    check(med_phy_model_inst.tx_q[1], 6'h1A);
    check(med_phy_model_inst.tx_q[2], 6'h35);
    check(med_phy_model_inst.tx_q[3], 6'h00);
    // mii receive: only valid beats reach the mac
    med_phy_model_inst.send_rx(4'h3, 1'b1, 1'b0);
    med_phy_model_inst.send_rx(4'hC, 1'b1, 1'b1);
    med_phy_model_inst.send_rx(4'h9, 1'b0, 1'b0);
    repeat (4) @(posedge sys_clk);
    check(rx_q.size(), 2);
    check(rx_q[0], 5'h03);
    check(rx_q[1], 5'h1C);
    rx_q.delete();
    // codec mode: gp outputs follow control bits
    foreach (ctl[i]) begin
      c = ctl[i];
      wr(CTRL, 32'(c));
      repeat (2) @(posedge sys_clk);
      check(32'(mdc), 32'(c[LB] ^ c[VB]));
      check({mdio_oe, mdio_o}, {1'b1, c[CB]});
      check(txd[3:2], {c[P0], c[P1]});
      check({txd1_oe, txd[1]}, {c[PD], ~c[PD]});
      check(32'(txer), 32'(c[LD]));
    end
    // codec transmit: serial bit on line 0, error input unused
    wr(CTRL, 32'h1);
    tx_run(4'hF, 4'hE, 1'b1, 1'b0);
    check(med_phy_model_inst.tx_q[1], 6'h13);
    check(med_phy_model_inst.tx_q[2], 6'h12);
    // codec receive: line 0 only
    med_phy_model_inst.send_rx(4'hF, 1'b0, 1'b1);
    med_phy_model_inst.send_rx(4'hE, 1'b1, 1'b0);
    repeat (4) @(posedge sys_clk);
    check(rx_q.size(), 2);
    check(rx_q[0], 5'h01);
    check(rx_q[1], 5'h00);
    // codec gp inputs through the synchroniser into status
    foreach (gpt[i]) begin
      med_phy_model_inst.set_gp(gpt[i][5:2], gpt[i][1], gpt[i][0]);
      repeat (4) @(posedge sys_clk);
      rd(STA, v);
      check({v[S3], v[S2], v[S1]}, gpt[i][5:3]);
      check({v[SV], v[SE]}, gpt[i][1:0]);
    end
    wrap_up();
  end
endmodule : med_mii_if_tb
